// File: gp_edge.sv
// Edge detector with a selectable polarity for one synchronised pin.
`timescale 1ns/1ns
`default_nettype none
module gp_edge (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_level,
   input  wire logic i_rise,
   output logic      o_pulse
);
   typedef struct packed {
      logic prev;
   } gp_edge_st_t;

   gp_edge_st_t st_q;
   gp_edge_st_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.prev = i_level;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_pulse = i_rise ? (i_level & ~st_q.prev) : (~i_level & st_q.prev);

   edge_pol_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_pulse |-> (i_level == i_rise) && ($past(i_level) != i_rise))
      else $error("edge pulse does not match the selected polarity");
endmodule
`default_nettype wire

// File: gp_pins.sv
// Board-side model of the pin bank that the port drives and samples.
`timescale 1ns/1ns
`default_nettype none
module gp_pins (
   input  wire logic [31:0] i_pin_out,
   input  wire logic [31:0] i_pin_oe,
   input  wire logic [31:0] i_board,
   output logic      [31:0] o_pin_in
);
   // The board only sets a level where the port has let go of the pin, so a driven pin reads back its own value.
   assign o_pin_in = (i_pin_out & i_pin_oe) | (i_board & ~i_pin_oe);
endmodule
`default_nettype wire

// File: gp_pkg.sv
// Constants shared by the general purpose pin port and its testbench.
package gp_pkg;
   // ******************************************************************
   // Register indices; the byte address is four times the index.
   // ******************************************************************
   localparam logic [15:0] IDX_CTRL     = 16'hc006;
   localparam logic [15:0] IDX_OUT_LO   = 16'hc01e;
   localparam logic [15:0] IDX_IN_LO    = 16'hc020;
   localparam logic [15:0] IDX_DIR_LO   = 16'hc022;
   localparam logic [15:0] IDX_OUT_HI   = 16'hc024;
   localparam logic [15:0] IDX_IN_HI    = 16'hc026;
   localparam logic [15:0] IDX_DIR_HI   = 16'hc028;
   localparam logic [15:0] IDX_IRQ_STAT = 16'hc0f0;
   localparam logic [15:0] IDX_IRQ_MASK = 16'hc0f2;

   // ******************************************************************
   // Control register fields.
   // ******************************************************************
   localparam int          CTRL_INT0_EN  = 0;
   localparam int          CTRL_INT0_POL = 1;
   localparam int          CTRL_INT1_EN  = 2;
   localparam int          CTRL_INT1_POL = 3;
   localparam int          CTRL_MODE_LSB = 8;
   localparam int          CTRL_WP       = 15;
   localparam logic [15:0] CTRL_WMASK    = 16'hcfff;
   localparam logic [15:0] CTRL_WP_KEEP  = 16'hff00;
   localparam logic [2:0]  MODE_GPIO     = 3'h0;

   // ******************************************************************
   // Pin numbers and pin groups.
   // ******************************************************************
   localparam int          PIN_INT0      = 24;
   localparam int          PIN_INT1      = 25;
   localparam logic [31:0] MODE_PINS     = 32'h01f8ffff;

   // ******************************************************************
   // Values after reset.
   // ******************************************************************
   localparam logic [15:0] RST_HALF      = 16'h0000;
   localparam logic [1:0]  RST_IRQ       = 2'h0;
   localparam logic [31:0] RST_WORD      = 32'h00000000;
endpackage

// File: gp_port.sv
// Thirty-two pin general purpose port with an APB register slave.
//
// Summary of operation
// - Pin 24 edges set status only with the enable bit set; status reaches the output only with the mask bit set.
// - Low output word drives pins 15..0, high output word drives pins 31..16.
// - Reading an output word returns the last value written, not the pins.
// - Input words return sampled levels of pins 15..0 and 31..16.
// - Writes to the input words change nothing.
// - Direction bit one drives the pin from its output bit (shared pins only with pin function field 000); zero makes it input.
// - Direction words cover the two pin halves and clear to zero at reset.
// - Both output words clear to zero at reset.
// - Polarity bit picks rising (one) or falling (zero) edges for pin 24.
// - Pin function field 000 keeps pins 15..0 and 24..19 as plain pins.
`timescale 1ns/1ns
`default_nettype none
module gp_port #(
   parameter int ADDR_W = 18
) (
   input  wire logic              I_SYS_CLK,
   input  wire logic              I_RST_B,
   input  wire logic              I_PSEL,
   input  wire logic              I_PENABLE,
   input  wire logic              I_PWRITE,
   input  wire logic [ADDR_W-1:0] I_PADDR,
   input  wire logic [31:0]       I_PWDATA,
   input  wire logic [3:0]        I_PSTRB,
   output logic      [31:0]       O_PRDATA,
   output logic                   O_PREADY,
   output logic                   O_PSLVERR,
   input  wire logic [31:0]       I_PIN_IN,
   output logic      [31:0]       O_PIN_OUT,
   output logic      [31:0]       O_PIN_OE,
   output logic                   O_IRQ
);
   // ******************************************************************
   // State.
   // ******************************************************************
   typedef enum logic [3:0] {
      SEL_NONE,
      SEL_CTRL,
      SEL_OUT_LO,
      SEL_IN_LO,
      SEL_DIR_LO,
      SEL_OUT_HI,
      SEL_IN_HI,
      SEL_DIR_HI,
      SEL_STAT,
      SEL_MASK
   } gp_sel_t;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] out_lo;
      logic [15:0] out_hi;
      logic [15:0] dir_lo;
      logic [15:0] dir_hi;
      logic [1:0]  stat;
      logic [1:0]  mask;
      logic [31:0] oe;
      logic        irq;
      logic        ready;
      logic        slverr;
      logic [31:0] rdata;
   } gp_port_st_t;

   gp_port_st_t st_q;
   gp_port_st_t st_d;
   logic [31:0] pin_sync;
   logic        edge0;
   logic        edge1;

   // ******************************************************************
   // Address decode.
   // ******************************************************************
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
      byte_addr = ADDR_W'({idx, 2'b00});
   endfunction

   function automatic gp_sel_t decode(input logic [ADDR_W-1:0] a);
      if (a == byte_addr(gp_pkg::IDX_CTRL)) begin
         decode = SEL_CTRL;
      end else if (a == byte_addr(gp_pkg::IDX_OUT_LO)) begin
         decode = SEL_OUT_LO;
      end else if (a == byte_addr(gp_pkg::IDX_IN_LO)) begin
         decode = SEL_IN_LO;
      end else if (a == byte_addr(gp_pkg::IDX_DIR_LO)) begin
         decode = SEL_DIR_LO;
      end else if (a == byte_addr(gp_pkg::IDX_OUT_HI)) begin
         decode = SEL_OUT_HI;
      end else if (a == byte_addr(gp_pkg::IDX_IN_HI)) begin
         decode = SEL_IN_HI;
      end else if (a == byte_addr(gp_pkg::IDX_DIR_HI)) begin
         decode = SEL_DIR_HI;
      end else if (a == byte_addr(gp_pkg::IDX_IRQ_STAT)) begin
         decode = SEL_STAT;
      end else if (a == byte_addr(gp_pkg::IDX_IRQ_MASK)) begin
         decode = SEL_MASK;
      end else begin
         decode = SEL_NONE;
      end
   endfunction

   // ******************************************************************
   // Pin inputs.
   // ******************************************************************
   gp_sync #(
      .W       (32)
   ) u_sync (
      .i_clk   (I_SYS_CLK),
      .i_rst_b (I_RST_B),
      .i_async (I_PIN_IN),
      .o_sync  (pin_sync)
   );

   gp_edge u_edge0 (
      .i_clk   (I_SYS_CLK),
      .i_rst_b (I_RST_B),
      .i_level (pin_sync[gp_pkg::PIN_INT0]),
      .i_rise  (st_q.ctrl[gp_pkg::CTRL_INT0_POL]),
      .o_pulse (edge0)
   );

   gp_edge u_edge1 (
      .i_clk   (I_SYS_CLK),
      .i_rst_b (I_RST_B),
      .i_level (pin_sync[gp_pkg::PIN_INT1]),
      .i_rise  (st_q.ctrl[gp_pkg::CTRL_INT1_POL]),
      .o_pulse (edge1)
   );

   // ******************************************************************
   // Next state.
   // ******************************************************************
   // Only the two low byte lanes carry data; upper strobes are ignored.
   always_comb begin
      gp_sel_t     sel;
      logic        setup;
      logic        wr;
      logic [15:0] wd;
      logic [15:0] wm;
      logic [1:0]  ev;
      logic [1:0]  clr;
      sel   = decode(I_PADDR);
      setup = I_PSEL & ~I_PENABLE;
      wr    = I_PSEL & I_PENABLE & st_q.ready & I_PWRITE;
      wm    = {{8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
      wd    = I_PWDATA[15:0];
      clr   = 2'h0;
      // A new event wins over a write-one clear in the same cycle.
      ev[0] = edge0 & st_q.ctrl[gp_pkg::CTRL_INT0_EN];
      ev[1] = edge1 & st_q.ctrl[gp_pkg::CTRL_INT1_EN];
      st_d  = st_q;
      st_d.ready  = setup;
      st_d.slverr = setup & (sel == SEL_NONE);
      if (wr) begin
         unique case (sel)
            SEL_CTRL: begin
               wm = wm & gp_pkg::CTRL_WMASK;
               if (st_q.ctrl[gp_pkg::CTRL_WP]) begin
                  wm = wm & ~gp_pkg::CTRL_WP_KEEP;
               end
               st_d.ctrl = (st_q.ctrl & ~wm) | (wd & wm);
            end
            SEL_OUT_LO: st_d.out_lo = (st_q.out_lo & ~wm) | (wd & wm);
            SEL_OUT_HI: st_d.out_hi = (st_q.out_hi & ~wm) | (wd & wm);
            SEL_DIR_LO: st_d.dir_lo = (st_q.dir_lo & ~wm) | (wd & wm);
            SEL_DIR_HI: st_d.dir_hi = (st_q.dir_hi & ~wm) | (wd & wm);
            SEL_STAT:   clr = wd[1:0] & wm[1:0];
            SEL_MASK:   st_d.mask = (st_q.mask & ~wm[1:0]) | (wd[1:0] & wm[1:0]);
            SEL_IN_LO, SEL_IN_HI, SEL_NONE: begin
               st_d.slverr = 1'b0;
            end
         endcase
      end
      st_d.stat = (st_q.stat & ~clr) | ev;
      st_d.irq  = |(st_d.stat & st_d.mask);
      // Non-plain pin modes hand the shared pins to other functions, so we release them.
      if (st_d.ctrl[gp_pkg::CTRL_MODE_LSB +: 3] == gp_pkg::MODE_GPIO) begin
         st_d.oe = {st_d.dir_hi, st_d.dir_lo};
      end else begin
         st_d.oe = {st_d.dir_hi, st_d.dir_lo} & ~gp_pkg::MODE_PINS;
      end
      st_d.rdata = gp_pkg::RST_WORD;
      if (setup & ~I_PWRITE) begin
         unique case (sel)
            SEL_CTRL:   st_d.rdata = {16'h0000, st_q.ctrl};
            SEL_OUT_LO: st_d.rdata = {16'h0000, st_q.out_lo};
            SEL_OUT_HI: st_d.rdata = {16'h0000, st_q.out_hi};
            SEL_IN_LO:  st_d.rdata = {16'h0000, pin_sync[15:0]};
            SEL_IN_HI:  st_d.rdata = {16'h0000, pin_sync[31:16]};
            SEL_DIR_LO: st_d.rdata = {16'h0000, st_q.dir_lo};
            SEL_DIR_HI: st_d.rdata = {16'h0000, st_q.dir_hi};
            SEL_STAT:   st_d.rdata = {30'h00000000, st_q.stat};
            SEL_MASK:   st_d.rdata = {30'h00000000, st_q.mask};
            SEL_NONE:   st_d.rdata = gp_pkg::RST_WORD;
         endcase
      end
   end

   // ******************************************************************
   // Registers.
   // ******************************************************************
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_q        <= '0;
         st_q.out_lo <= gp_pkg::RST_HALF;
         st_q.out_hi <= gp_pkg::RST_HALF;
         st_q.dir_lo <= gp_pkg::RST_HALF;
         st_q.dir_hi <= gp_pkg::RST_HALF;
         st_q.stat   <= gp_pkg::RST_IRQ;
         st_q.mask   <= gp_pkg::RST_IRQ;
      end else begin
         st_q <= st_d;
      end
   end

   assign O_PRDATA  = st_q.rdata;
   assign O_PREADY  = st_q.ready;
   assign O_PSLVERR = st_q.slverr;
   assign O_PIN_OUT = {st_q.out_hi, st_q.out_lo};
   assign O_PIN_OE  = st_q.oe;
   assign O_IRQ     = st_q.irq;

   // ******************************************************************
   // Checks.
   // ******************************************************************
   irq_gate_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      O_IRQ == |(st_q.stat & st_q.mask))
      else $error("interrupt output does not follow masked status");

   int0_set_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (edge0 && st_q.ctrl[gp_pkg::CTRL_INT0_EN]) |=> st_q.stat[0])
      else $error("enabled pin 24 edge did not set its status bit");

   int0_off_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (!st_q.stat[0] && !st_q.ctrl[gp_pkg::CTRL_INT0_EN]) |=> !st_q.stat[0])
      else $error("disabled pin 24 interrupt set its status bit");

   pin_drive_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && decode(I_PADDR) == SEL_OUT_LO && I_PSTRB[1:0] == 2'h3)
      |=> O_PIN_OUT[15:0] == $past(I_PWDATA[15:0]))
      else $error("pin outputs differ from written output word");

   dir_oe_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (st_q.ctrl[gp_pkg::CTRL_MODE_LSB +: 3] == gp_pkg::MODE_GPIO)
      |-> O_PIN_OE == {st_q.dir_hi, st_q.dir_lo})
      else $error("pin enables differ from direction words");

   mode_release_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (st_q.ctrl[gp_pkg::CTRL_MODE_LSB +: 3] != gp_pkg::MODE_GPIO)
      |-> (O_PIN_OE & gp_pkg::MODE_PINS) == 32'h00000000)
      else $error("shared pins driven outside plain pin mode");

   out_read_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE && decode(I_PADDR) == SEL_OUT_LO
       && $stable(st_q.out_lo)) |-> O_PRDATA == {16'h0000, st_q.out_lo})
      else $error("output word read back wrong value");

   in_read_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE && decode(I_PADDR) == SEL_IN_HI)
      |-> O_PRDATA == {16'h0000, $past(pin_sync[31:16])})
      else $error("input word read back wrong value");

   in_ro_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && decode(I_PADDR) == SEL_IN_LO)
      |=> $stable({st_q.ctrl, st_q.out_lo, st_q.out_hi, st_q.dir_lo, st_q.dir_hi, st_q.mask}))
      else $error("write to input word changed a register");

   apb_ready_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
      (I_PSEL && !I_PENABLE) |=> O_PREADY ##1 !O_PREADY || (I_PSEL && !I_PENABLE))
      else $error("ready did not follow the setup cycle");
endmodule
`default_nettype wire

// File: gp_sync.sv
// Two-stage synchroniser for a bus of pin inputs.
`timescale 1ns/1ns
`default_nettype none
module gp_sync #(
   parameter int W = 32
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } gp_sync_st_t;

   gp_sync_st_t st_q;
   gp_sync_st_t st_d;

   // The first stage feeds the second stage only, to keep metastability contained.
   always_comb begin
      st_d      = st_q;
      st_d.meta = i_async;
      st_d.sync = st_q.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q.sync;

   two_stage_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $past(i_rst_b) |-> ##2 o_sync == $past(i_async, 2))
      else $error("synchroniser output is not the input two cycles late");
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the general purpose pin port.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [17:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] pin_in;
   logic [31:0] pin_out;
   logic [31:0] pin_oe;
   logic        irq;
   logic [31:0] board;
   logic [31:0] rdat;
   logic        rerr;
   int          n_errors;
   int          check_count;

   gp_port u_dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
                  .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hf), .O_PRDATA(prdata), .O_PREADY(pready),
                  .O_PSLVERR(pslverr), .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_IRQ(irq));
   gp_pins u_pins (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_board(board), .o_pin_in(pin_in));

   always #2 clk = ~clk;

   // ******************************************************************
   // Bus and compare helpers.
   // ******************************************************************
   task finish_test();
      $display("Checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Every bus wait is bounded, so a slave that never answers ends the run instead of hanging it.
   task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         finish_test();
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [15:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
      chk({31'h0, rerr}, 32'h0);
   endtask

   task rd(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk({31'h0, rerr}, 32'h0);
      chk(rdat, exp);
   endtask

   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task pin24(input logic v);
      @(posedge clk);
      board[24] <= v;
   endtask

   // The pin passes two sync stages, so the line must stay low for at least two edges after the pin moves.
   task wait_irq();
      int i;
      for (i = 0; i < 12; i++) begin
         @(posedge clk);
         if (irq === 1'b1) break;
      end
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, i >= 2}, 32'h1);
   endtask

   // ******************************************************************
   // Scenarios.
   // ******************************************************************
   task t_reset();
      rd(gp_pkg::IDX_OUT_LO, 32'h0);
      rd(gp_pkg::IDX_OUT_HI, 32'h0);
      rd(gp_pkg::IDX_DIR_LO, 32'h0);
      rd(gp_pkg::IDX_DIR_HI, 32'h0);
      chk(pin_oe, 32'h0);
      chk(pin_out, 32'h0);
      $display("test reset done");
   endtask

   task t_out_dir();
      wr(gp_pkg::IDX_OUT_LO, 32'ha5c3);
      wr(gp_pkg::IDX_OUT_HI, 32'h3c96);
      idle(2);
      chk(pin_out, 32'h3c96a5c3);
      rd(gp_pkg::IDX_OUT_LO, 32'ha5c3);
      rd(gp_pkg::IDX_OUT_HI, 32'h3c96);
      wr(gp_pkg::IDX_DIR_LO, 32'h00ff);
      wr(gp_pkg::IDX_DIR_HI, 32'h00f0);
      idle(2);
      chk(pin_oe, 32'h00f000ff);
      idle(3);
      rd(gp_pkg::IDX_IN_LO, (32'ha5c3 & 32'h00ff) | (32'h0ff0 & 32'hff00));
      rd(gp_pkg::IDX_IN_HI, (32'h3c96 & 32'h00f0) | (32'h5a5a & 32'hff0f));
      rd(gp_pkg::IDX_DIR_HI, 32'h00f0);
      rd(gp_pkg::IDX_OUT_HI, 32'h3c96);
      $display("test output and direction done");
   endtask

   task t_refused();
      wr(gp_pkg::IDX_IN_LO, 32'hffff);
      rd(gp_pkg::IDX_IN_LO, 32'h0fc3);
      rd(gp_pkg::IDX_OUT_LO, 32'ha5c3);
      apb(1'b0, 16'hc100, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      apb(1'b1, 16'hc100, 32'h1234);
      chk({31'h0, rerr}, 32'h1);
      $display("test refused accesses done");
   endtask

   task t_mode();
      wr(gp_pkg::IDX_CTRL, 32'h0100);
      idle(2);
      chk(pin_oe & gp_pkg::MODE_PINS, 32'h0);
      wr(gp_pkg::IDX_CTRL, 32'h0000);
      idle(2);
      chk(pin_oe, 32'h00f000ff);
      $display("test pin function done");
   endtask

   task t_irq();
      wr(gp_pkg::IDX_IRQ_MASK, 32'h1);
      wr(gp_pkg::IDX_CTRL, 32'h0003);
      rd(gp_pkg::IDX_CTRL, 32'h0003);
      pin24(1'b1);
      wait_irq();
      rd(gp_pkg::IDX_IRQ_STAT, 32'h1);
      wr(gp_pkg::IDX_IRQ_STAT, 32'h1);
      rd(gp_pkg::IDX_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      pin24(1'b0);
      idle(10);
      chk({31'h0, irq}, 32'h0);
      wr(gp_pkg::IDX_CTRL, 32'h0001);
      pin24(1'b1);
      idle(10);
      chk({31'h0, irq}, 32'h0);
      pin24(1'b0);
      wait_irq();
      wr(gp_pkg::IDX_IRQ_STAT, 32'h1);
      wr(gp_pkg::IDX_CTRL, 32'h0000);
      pin24(1'b1);
      pin24(1'b0);
      idle(10);
      rd(gp_pkg::IDX_IRQ_STAT, 32'h0);
      wr(gp_pkg::IDX_IRQ_MASK, 32'h0);
      wr(gp_pkg::IDX_CTRL, 32'h0001);
      pin24(1'b1);
      pin24(1'b0);
      idle(10);
      rd(gp_pkg::IDX_IRQ_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      $display("test interrupt done");
   endtask

   // ******************************************************************
   // Main sequence.
   // ******************************************************************
   initial begin
      clk         = 1'b0;
      rst_b       = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 18'h0;
      pwdata      = 32'h0;
      board       = 32'h5a5a0ff0;
      n_errors    = 0;
      check_count = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_out_dir();
      t_refused();
      t_mode();
      t_irq();
      finish_test();
   end
endmodule
`default_nettype wire
